/* File: crh_port.sv */
// Card reader host port: commands, status, column data, test mode, interrupts.
//
// Overview of operation
// - Status 2 shows stacker full after last read
// - Status 2 shows fail to feed
// - Status 2 shows stacker area jam
// - Data transfer returns column on bits 0-11
// - Each returned bit is one punched row
// - Transfer needs ready, data, no violation, no alarm
// - Transfer of the last buffered column clears data status and data response
// - Test write with bit 0 set enters self-test
// - Test write accepted only when both idle
// - Self-test ends only on a test write with bit 0 low
// - Self-test loops data and control to partner
// - Five interrupt signals are generated
// - Common interrupt ORs data, done, alarm
// - Auto interrupt: auto mode, data, no others
// - Auto interrupt cleared by clears or transfer
// - Jumpers route any source to either line
// - Default jumpers: common macro, auto micro
// - Command bits select transfer, status, function, test
// - Protect rejects unprotected non-status requests
// - Lost data blocks transfers until operation done, a new feed or a clear control
`include "crh_params.svh"
`timescale 1ns/1ns
`default_nettype none
module crh_port (
   // Clock and reset
   input  wire logic                     i_mclk,
   input  wire logic                     i_arst_n,
   // Processor request and answer
   input  wire logic                     i_io_req,
   input  wire crh_pkg::crh_req_t        i_io_cmd,
   output logic                          o_io_reply,
   output logic                          o_io_reject,
   output logic [`CRH_WORD_W-1:0]        o_io_rdata,
   // Reader mechanism, same clock
   input  wire crh_pkg::crh_col_t        i_rdr_col,
   input  wire logic                     i_rdr_done,
   output logic                          o_rdr_feed,
   // Reader and partner pins, asynchronous
   input  wire logic                     i_rdr_ready,
   input  wire logic                     i_rdr_stacker_full,
   input  wire logic                     i_rdr_feed_fail,
   input  wire logic                     i_rdr_jam,
   input  wire logic                     i_rdr_hopper_empty,
   input  wire logic                     i_protect_sw,
   input  wire logic                     i_prn_busy,
   // Loop-back with the printer controller in self-test
   input  wire crh_pkg::crh_col_t        i_loop_col,
   input  wire logic                     i_loop_done,
   output logic                          o_loop_feed,
   output logic                          o_test_mode,
   // Interrupt jumper straps, static
   input  wire logic [2:0]               i_jmp_macro,
   input  wire logic [2:0]               i_jmp_micro,
   // Interrupt outputs
   output logic [`CRH_NUM_INT-1:0]       o_int_src,
   output logic                          o_int_macro,
   output logic                          o_int_micro
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [`CRH_PIN_W-1:0] pin_raw;
   logic [`CRH_PIN_W-1:0] pin_s1;
   logic [`CRH_PIN_W-1:0] pin_s2;
   logic [`CRH_PIN_W-1:0] pin_s3;
   logic [`CRH_PIN_W-1:0] pin;

   assign pin_raw = {i_prn_busy, i_protect_sw, i_rdr_hopper_empty, i_rdr_jam,
                     i_rdr_feed_fail, i_rdr_stacker_full, i_rdr_ready};

   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // Filtered levels; a one-cycle glitch never passes both stages
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin <= '0;
      end else begin
         for (int i = 0; i < `CRH_PIN_W; i++) begin
            if (pin_s2[i] == pin_s3[i]) begin
               pin[i] <= pin_s3[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Jumper straps, caught after reset release

   logic       strap_done;
   logic [2:0] sel_macro;
   logic [2:0] sel_micro;

   // Reset loads the standard assignment; the straps replace it one cycle after release
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         strap_done <= 1'b0;
         sel_macro  <= `CRH_INT_COMMON;
         sel_micro  <= `CRH_INT_AUTO;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         sel_macro  <= i_jmp_macro;
         sel_micro  <= i_jmp_micro;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Column path and buffer

   crh_pkg::crh_col_t col_in;
   logic                    fifo_in_ready;
   logic                    fifo_out_valid;
   logic [`CRH_COL_W-1:0]   fifo_out_data;
   logic                    xfer_ok;
   logic                    done_evt;

   // Self-test swaps the reader for the printer loop-back
   assign col_in   = o_test_mode ? i_loop_col : i_rdr_col;
   assign done_evt = o_test_mode ? i_loop_done : i_rdr_done;

   // Bit n set means a hole sensed in row n of the column
   crh_fifo #(
      .WIDTH (`CRH_COL_W),
      .DEPTH (`CRH_FIFO_DEPTH)
   ) u_col_fifo (
      .i_mclk      (i_mclk),
      .i_arst_n    (i_arst_n),
      .i_in_valid  (col_in.valid),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (col_in.rows),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (xfer_ok),
      .o_out_data  (fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Request decode

   logic busy;
   logic done_stat;
   logic lost;
   logic adt_mode;
   logic en_data;
   logic en_done;
   logic en_alarm;
   logic done_resp;
   logic alarm;
   logic ready;
   logic is_read;
   logic is_write;
   logic is_stat;
   logic prot_viol;
   logic dir_ok;
   logic test_ok;
   logic dir_clr;
   logic dir_clr_int;
   logic legal;

   assign ready     = pin[`CRH_PIN_READY];
   assign alarm     = lost | pin[`CRH_PIN_JAM] | pin[`CRH_PIN_FEEDFAIL];
   assign is_read   = i_io_req && i_io_cmd.read && !i_io_cmd.write;
   assign is_write  = i_io_req && i_io_cmd.write && !i_io_cmd.read;
   assign is_stat   = is_read && (i_io_cmd.cmd == `CRH_CMD_STAT1 ||
                                  i_io_cmd.cmd == `CRH_CMD_STAT2);
   // Status requests are answered whatever the protect state
   assign prot_viol = pin[`CRH_PIN_PROT] && !i_io_cmd.protect;

   // Code table: read 00/01/11, write 01/10
   assign legal = (is_read  && i_io_cmd.cmd != `CRH_CMD_TEST) ||
                  (is_write && (i_io_cmd.cmd == `CRH_CMD_STAT1 ||
                                i_io_cmd.cmd == `CRH_CMD_TEST));

   // Transfer gate; lost data holds it shut until the operation ends, a new feed or a clear control
   assign xfer_ok = is_read && i_io_cmd.cmd == `CRH_CMD_XFER && ready &&
                    fifo_out_valid && !prot_viol && !alarm;

   // A not-ready reader still takes a pure clear
   assign dir_ok  = is_write && i_io_cmd.cmd == `CRH_CMD_STAT1 && !prot_viol &&
                    (ready || (i_io_cmd.data & `CRH_DIR_SET_MASK) == `CRH_ZERO_WORD);
   assign test_ok = is_write && i_io_cmd.cmd == `CRH_CMD_TEST && !prot_viol &&
                    !busy && !pin[`CRH_PIN_PRN_BUSY];

   assign dir_clr     = dir_ok && i_io_cmd.data[`CRH_DIR_CLR_CTRL];
   assign dir_clr_int = dir_ok && (i_io_cmd.data[`CRH_DIR_CLR_INT] || dir_clr);

   ////////////////////////////////////////////////////////////////////////
   // Status words

   logic [`CRH_WORD_W-1:0] stat1;
   logic [`CRH_WORD_W-1:0] stat2;

   always_comb begin
      stat1                 = `CRH_ZERO_WORD;
      stat1[`CRH_S1_READY]  = ready;
      stat1[`CRH_S1_BUSY]   = busy;
      stat1[`CRH_S1_INT]    = o_int_macro;
      stat1[`CRH_S1_DATA]   = fifo_out_valid;
      stat1[`CRH_S1_DONE]   = done_stat;
      stat1[`CRH_S1_ALARM]  = alarm;
      stat1[`CRH_S1_LOST]   = lost;
      stat1[`CRH_S1_PROT]   = pin[`CRH_PIN_PROT];
      stat1[`CRH_S1_NREADY] = !ready;
      stat1[`CRH_S1_AUTO]   = adt_mode;
   end

   // Only four error bits carry meaning; the rest stay zero
   always_comb begin
      stat2                   = `CRH_ZERO_WORD;
      stat2[`CRH_S2_HOPPER]   = pin[`CRH_PIN_HOPPER];
      stat2[`CRH_S2_STACKER]  = pin[`CRH_PIN_STACKER];
      stat2[`CRH_S2_FEEDFAIL] = pin[`CRH_PIN_FEEDFAIL];
      stat2[`CRH_S2_JAM]      = pin[`CRH_PIN_JAM];
   end

   ////////////////////////////////////////////////////////////////////////
   // Answer to the processor

   crh_pkg::crh_ans_t ans;

   // Anything not taken gets the external reject
   always_comb begin
      if (!i_io_req) begin
         ans = crh_pkg::CRH_ANS_NONE;
      end else if (legal && (is_stat || xfer_ok || dir_ok || test_ok)) begin
         ans = crh_pkg::CRH_ANS_REPLY;
      end else begin
         ans = crh_pkg::CRH_ANS_REJECT;
      end
   end

   // One-cycle strobes; read data holds until the next accepted read
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_io_reply  <= 1'b0;
         o_io_reject <= 1'b0;
         o_io_rdata  <= `CRH_ZERO_WORD;
      end else begin
         o_io_reply  <= (ans == crh_pkg::CRH_ANS_REPLY);
         o_io_reject <= (ans == crh_pkg::CRH_ANS_REJECT);
         if (xfer_ok) begin
            o_io_rdata <= {{(`CRH_WORD_W-`CRH_COL_W){1'b0}}, fifo_out_data};
         end else if (is_stat && i_io_cmd.cmd == `CRH_CMD_STAT1) begin
            o_io_rdata <= stat1;
         end else if (is_stat) begin
            o_io_rdata <= stat2;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Self-test mode

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_test_mode <= 1'b0;
      end else if (test_ok) begin
         o_test_mode <= i_io_cmd.data[`CRH_TEST_ON];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Feed and operation tracking

   logic feed;

   assign feed = dir_ok && i_io_cmd.data[`CRH_DIR_FEED];

   // Feed goes to the reader, or to the partner while in self-test
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdr_feed  <= 1'b0;
         o_loop_feed <= 1'b0;
      end else begin
         o_rdr_feed  <= feed && !o_test_mode;
         o_loop_feed <= feed && o_test_mode;
      end
   end

   // Busy from feed until done; a second feed restarts the cycle
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         busy      <= 1'b0;
         done_stat <= 1'b0;
      end else begin
         if (feed) begin
            busy      <= 1'b1;
            done_stat <= 1'b0;
         end else if (done_evt) begin
            busy      <= 1'b0;
            done_stat <= 1'b1;
         end else if (dir_clr) begin
            done_stat <= 1'b0;
         end
      end
   end

   // Column arriving into a full buffer is lost; done ends the block
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lost <= 1'b0;
      end else if (col_in.valid && !fifo_in_ready) begin
         lost <= 1'b1;
      end else if (feed || dir_clr || done_evt) begin
         lost <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt enables and mode

   // Clears act first, so stacked enables in the same word survive
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         en_data  <= 1'b0;
         en_done  <= 1'b0;
         en_alarm <= 1'b0;
         adt_mode <= 1'b0;
      end else if (dir_ok) begin
         en_data  <= (en_data && !dir_clr_int) || i_io_cmd.data[`CRH_DIR_INT_DATA];
         en_done  <= (en_done && !dir_clr_int) || i_io_cmd.data[`CRH_DIR_INT_DONE];
         en_alarm <= (en_alarm && !dir_clr_int) || i_io_cmd.data[`CRH_DIR_INT_ALARM];
         adt_mode <= i_io_cmd.data[`CRH_DIR_AUTO];
      end
   end

   // Done response is sticky; a done event beats a same-cycle clear
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         done_resp <= 1'b0;
      end else if (done_evt && (en_done || (dir_ok && i_io_cmd.data[`CRH_DIR_INT_DONE]))) begin
         done_resp <= 1'b1;
      end else if (dir_clr_int) begin
         done_resp <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt sources and routing

   logic                     int_data;
   logic                     int_done;
   logic                     int_alarm;
   logic                     int_common;
   logic                     next_int_auto;
   logic                     int_auto;
   logic [`CRH_NUM_INT-1:0]  int_vec;

   // Data response drops while the buffer is empty after a transfer
   assign int_data   = en_data && fifo_out_valid && !xfer_ok;
   assign int_done   = done_resp;
   assign int_alarm  = en_alarm && alarm;
   assign int_common = int_data | int_done | int_alarm;
   assign next_int_auto = adt_mode && int_data && !int_done && !int_alarm;

   // Held in a flop so a transfer or clear drops it for a cycle
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         int_auto <= 1'b0;
      end else if (xfer_ok || dir_clr_int) begin
         int_auto <= 1'b0;
      end else begin
         int_auto <= next_int_auto;
      end
   end

   assign int_vec = {int_auto, int_common, int_alarm, int_done, int_data};

   // Out-of-range jumper code drives its line low
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_int_src   <= '0;
         o_int_macro <= 1'b0;
         o_int_micro <= 1'b0;
      end else begin
         o_int_src   <= int_vec;
         o_int_macro <= (sel_macro < `CRH_NUM_INT) ? int_vec[sel_macro] : 1'b0;
         o_int_micro <= (sel_micro < `CRH_NUM_INT) ? int_vec[sel_micro] : 1'b0;
      end
   end

endmodule
`default_nettype wire

/* File: crh_params.svh */
// Constants for the card reader host port: codes, bit positions, sizes.
`ifndef CRH_PARAMS_SVH
`define CRH_PARAMS_SVH

// Command codes in command word bits 1:0
`define CRH_CMD_XFER       2'h0
`define CRH_CMD_STAT1      2'h1
`define CRH_CMD_TEST       2'h2
`define CRH_CMD_STAT2      2'h3

// Director function bits of the write word
`define CRH_DIR_CLR_CTRL   0
`define CRH_DIR_CLR_INT    1
`define CRH_DIR_INT_DATA   2
`define CRH_DIR_INT_DONE   3
`define CRH_DIR_INT_ALARM  4
`define CRH_DIR_AUTO       6
`define CRH_DIR_FEED       7
`define CRH_DIR_SET_MASK   16'h00dc

// Test mode word bit
`define CRH_TEST_ON        0

// Status 1 bit positions
`define CRH_S1_READY       0
`define CRH_S1_BUSY        1
`define CRH_S1_INT         2
`define CRH_S1_DATA        3
`define CRH_S1_DONE        4
`define CRH_S1_ALARM       5
`define CRH_S1_LOST        6
`define CRH_S1_PROT        7
`define CRH_S1_NREADY      9
`define CRH_S1_AUTO        10

// Status 2 bit positions
`define CRH_S2_HOPPER      0
`define CRH_S2_STACKER     1
`define CRH_S2_FEEDFAIL    2
`define CRH_S2_JAM         5

// Widths and sizes
`define CRH_WORD_W         16
`define CRH_COL_W          12
`define CRH_FIFO_DEPTH     8
`define CRH_PIN_W          7
`define CRH_NUM_INT        5
`define CRH_ZERO_WORD      16'h0000

// Interrupt source indices for the jumper matrix
`define CRH_INT_DATA       3'h0
`define CRH_INT_DONE       3'h1
`define CRH_INT_ALARM      3'h2
`define CRH_INT_COMMON     3'h3
`define CRH_INT_AUTO       3'h4

// Pin vector positions
`define CRH_PIN_READY      0
`define CRH_PIN_STACKER    1
`define CRH_PIN_FEEDFAIL   2
`define CRH_PIN_JAM        3
`define CRH_PIN_HOPPER     4
`define CRH_PIN_PROT       5
`define CRH_PIN_PRN_BUSY   6

`endif

/* File: crh_pkg.sv */
// Types shared by the card reader host port and its column buffer.
package crh_pkg;

   // One processor I/O request, valid for one cycle
   typedef struct packed {
      logic        read;
      logic        write;
      logic        protect;
      logic [1:0]  cmd;
      logic [15:0] data;
   } crh_req_t;

   // One card column from the reader or the loop-back partner
   typedef struct packed {
      logic        valid;
      logic [11:0] rows;
   } crh_col_t;

   // Answer to a request
   typedef enum {CRH_ANS_NONE, CRH_ANS_REPLY, CRH_ANS_REJECT} crh_ans_t;

endpackage

/* File: crh_fifo.sv */
// Column buffer: flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module crh_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_arst_n,
   // Filling side
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   // Draining side
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   // Honest full and empty from the fill count
   assign o_in_ready  = (count != (AW+1)'(DEPTH));
   assign o_out_valid = (count != '0);
   assign o_out_data  = mem[rd_ptr];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   // Storage, written only on an accepted push
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   // Pointers wrap at the depth
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   // Fill level
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count <= '0;
      end else if (push && !pop) begin
         count <= count + 1'b1;
      end else if (pop && !push) begin
         count <= count - 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: crh_chk.sv */
// Concurrent checks on the card reader host port, bound to its ports.
`timescale 1ns/1ns
`default_nettype none
module crh_chk (
   // Clock and reset
   input wire logic              i_mclk,
   input wire logic              i_arst_n,
   // Processor port
   input wire logic              i_io_req,
   input wire crh_pkg::crh_req_t i_io_cmd,
   input wire logic              o_io_reply,
   input wire logic              o_io_reject,
   input wire logic [15:0]       o_io_rdata,
   // Test mode and interrupt sources
   input wire logic              o_test_mode,
   input wire logic [4:0]        o_int_src
);
   logic rd_req;
   // A clean read request; both or neither strobe is an illegal code anyway
   assign rd_req = i_io_req && i_io_cmd.read && !i_io_cmd.write;
   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_arst_n);
   ////////////////////////////////////////////////////////////////////////
   AST_ANSWER: assert property (i_io_req |=> o_io_reply != o_io_reject)
      else $error("request not answered by exactly one strobe");
   AST_REPLY: assert property (o_io_reply |-> $past(i_io_req))
      else $error("reply without a request");
   AST_ILLEGAL: assert property (rd_req && i_io_cmd.cmd == 2'h2 |=> o_io_reject)
      else $error("illegal read code accepted");
   AST_STATUS: assert property (rd_req && i_io_cmd.cmd == 2'h1 |=> o_io_reply)
      else $error("status 1 request refused");
   AST_XFER: assert property (rd_req && i_io_cmd.cmd == 2'h0 |=>
      !o_io_reply || o_io_rdata[15:12] == 4'h0) else $error("transfer upper bits set");
   AST_STAT2: assert property (rd_req && i_io_cmd.cmd == 2'h3 |=>
      o_io_reply && o_io_rdata[15:6] == 10'h000 && o_io_rdata[4:3] == 2'h0)
      else $error("status 2 refused or spare bits set");
   AST_COMMON: assert property (o_int_src[3] == (|o_int_src[2:0]))
      else $error("common source is not the or of the others");
   AST_AUTO: assert property ($rose(o_int_src[4]) |->
      !$past(o_int_src[1]) && !$past(o_int_src[2])) else $error("auto raised beside done or alarm");
   AST_TEST: assert property ($changed(o_test_mode) |-> o_io_reply || $past(o_io_reply))
      else $error("test mode moved without an accepted request");
   // Main scenarios reached
   cover property (rd_req && i_io_cmd.cmd == 2'h0 ##1 o_io_reply);
   cover property ($rose(o_test_mode));
   cover property ($rose(o_int_src[4]));
endmodule
bind crh_port crh_chk u_chk (.i_mclk, .i_arst_n, .i_io_req, .i_io_cmd,
   .o_io_reply, .o_io_reject, .o_io_rdata, .o_test_mode, .o_int_src);
`default_nettype wire

/* File: crh_rdr_model.sv */
// Card reader stand-in: each feed pulse yields one card of columns, then end of card.
`timescale 1ns/1ns
`default_nettype none
module crh_rdr_model (
   // Clock and reset
   input  wire logic         i_mclk,
   input  wire logic         i_arst_n,
   // Card shape from the bench
   input  wire logic [11:0]  i_base,
   input  wire logic [3:0]   i_ncol,
   input  wire logic [1:0]   i_gap,
   // Controller side
   input  wire logic         i_feed,
   output crh_pkg::crh_col_t o_col,
   output logic              o_done
);
   logic [3:0] sent;
   logic [4:0] tick;
   logic       run;
   // Column pacing; a second feed restarts the card like the real reader
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         run    <= 1'b0;
         sent   <= 4'h0;
         tick   <= 5'h00;
         o_col  <= '0;
         o_done <= 1'b0;
      end else begin
         o_done      <= 1'b0;
         o_col.valid <= 1'b0;
         o_col.rows  <= ~o_col.rows; // Stale rows flip so nothing looks held
         tick        <= tick + 5'h01;
         if (i_feed) begin
            run  <= 1'b1;
            sent <= 4'h0;
            tick <= 5'h00;
         end else if (run && sent != i_ncol && tick == {3'h0, i_gap}) begin
            o_col.valid <= 1'b1;
            o_col.rows  <= i_base + {8'h00, sent};
            sent        <= sent + 4'h1;
            tick        <= 5'h00;
         end else if (run && sent == i_ncol && tick == 5'h14) begin
            o_done <= 1'b1; // End of card comes well after the last column
            run    <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the card reader host port.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic              i_mclk = 1'b0, i_arst_n = 1'b0, i_io_req = 1'b0, i_rdr_ready = 1'b1;
   logic              i_protect_sw = 1'b0, i_prn_busy = 1'b0;
   logic [2:0]        i_jmp_macro = 3'h3, i_jmp_micro = 3'h4;
   logic [3:0]        pins = 4'h0, ncol = 4'h3;
   logic [11:0]       base = 12'hfff;
   logic [1:0]        gap = 2'h0, rep;
   logic [15:0]       s2_word [4] = '{16'h0002, 16'h0004, 16'h0020, 16'h0001};
   logic [2:0]        bad [4] = '{3'h6, 3'h0, 3'h3, 3'h4};
   crh_pkg::crh_req_t i_io_cmd = '0;
   crh_pkg::crh_col_t col, idle = '0;
   logic              o_io_reply, o_io_reject, o_rdr_feed, o_loop_feed, o_test_mode;
   logic              o_int_macro, o_int_micro, done;
   logic [15:0]       o_io_rdata;
   logic [4:0]        o_int_src;
   int                errors = 0, num_checks = 0;
   ////////////////////////////////////////////////////////////////////////
   // Reader columns reach the loop inputs only in test mode
   crh_port dut (.i_mclk, .i_arst_n, .i_io_req, .i_io_cmd, .o_io_reply, .o_io_reject,
      .o_io_rdata, .i_rdr_col(o_test_mode ? idle : col), .i_rdr_done(done & !o_test_mode),
      .o_rdr_feed, .i_rdr_ready, .i_rdr_stacker_full(pins[0]), .i_rdr_feed_fail(pins[1]),
      .i_rdr_jam(pins[2]), .i_rdr_hopper_empty(pins[3]), .i_protect_sw, .i_prn_busy,
      .i_loop_col(o_test_mode ? col : idle), .i_loop_done(done & o_test_mode), .o_loop_feed,
      .o_test_mode, .i_jmp_macro, .i_jmp_micro, .o_int_src, .o_int_macro, .o_int_micro);
   crh_rdr_model rdr (.i_mclk, .i_arst_n, .i_base(base), .i_ncol(ncol), .i_gap(gap),
      .i_feed(o_rdr_feed | o_loop_feed), .o_col(col), .o_done(done));
   // Transfer word of column n: rows low, four zero bits above
   function automatic logic [15:0] col_exp(input logic [11:0] b, input int n);
      return {4'h0, b + 12'(n)};
   endfunction
   // Compare and count; a mismatch is reported at once
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t ns: %s", $time, m);
      end
   endtask
   // One request for one edge; the one-cycle answer is caught while it stands
   task automatic io(input logic rd, input logic [1:0] c, input logic [15:0] d);
      @(negedge i_mclk);
      i_io_req = 1'b1;
      i_io_cmd = '{rd, !rd, 1'b0, c, d};
      @(negedge i_mclk);
      rep = {o_io_reply, o_io_reject};
      i_io_req = 1'b0;
      i_io_cmd = ~i_io_cmd;
      @(negedge i_mclk);
   endtask
   // Counts, verdict, stop
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial forever #25 i_mclk = ~i_mclk;
   // The run needs well under a thousand cycles; a hang ends here
   initial begin
      repeat (3000) @(posedge i_mclk);
      errors++;
      complete_run();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(61561));
      repeat (8) @(negedge i_mclk);
      i_arst_n = 1'b1;
      // Each error pin alone; pins pass a synchroniser, so settle first
      for (int p = 0; p < 4; p++) begin
         pins = 4'h1 << p;
         repeat (6) @(negedge i_mclk);
         io(1'b1, 2'h3, 16'h0000);
         chk(o_io_rdata, s2_word[p], "status 2 word");
      end
      pins = 4'h0;
      // Illegal codes, then a transfer from the empty buffer
      for (int i = 0; i < 4; i++) begin
         io(bad[i][2], bad[i][1:0], 16'h0000);
         chk({14'h0000, rep}, 16'h0001, "refused request");
      end
      i_protect_sw = 1'b1;
      repeat (6) @(negedge i_mclk);
      io(1'b0, 2'h1, 16'h0000);
      chk({14'h0000, rep}, 16'h0001, "unprotected function");
      i_protect_sw = 1'b0;
      repeat (6) @(negedge i_mclk);
      // Corner card from all ones wrapping to zero, then a random card; each at a random pace
      for (int k = 0; k < 2; k++) begin
         base = k ? 12'($urandom) : base;
         gap = 2'($urandom);
         io(1'b0, 2'h1, 16'h0084);
         repeat (20) @(negedge i_mclk);
         chk({14'h0000, o_int_macro, o_int_src[0]}, 16'h0003, "data interrupt");
         for (int n = 0; n < 3; n++) begin
            io(1'b1, 2'h0, 16'h0000);
            chk(o_io_rdata, col_exp(base, n), "column word");
         end
         io(1'b1, 2'h1, 16'h0000);
         chk({15'h0000, o_io_rdata[3]}, 16'h0000, "data status");
         repeat (30) @(negedge i_mclk);
      end
      // Auto mode with one column; the transfer drops the auto source
      ncol = 4'h1;
      io(1'b0, 2'h1, 16'h00c4);
      repeat (12) @(negedge i_mclk);
      chk({14'h0000, o_int_micro, o_int_src[4]}, 16'h0003, "auto interrupt");
      io(1'b1, 2'h0, 16'h0000);
      repeat (2) @(negedge i_mclk);
      chk({15'h0000, o_int_src[4]}, 16'h0000, "auto cleared");
      repeat (30) @(negedge i_mclk);
      // Test mode: refused while the printer is busy, then a looped card
      i_prn_busy = 1'b1;
      repeat (6) @(negedge i_mclk);
      io(1'b0, 2'h2, 16'h0001);
      chk({15'h0000, o_test_mode}, 16'h0000, "entry while busy");
      i_prn_busy = 1'b0;
      repeat (6) @(negedge i_mclk);
      io(1'b0, 2'h2, 16'h0001);
      chk({15'h0000, o_test_mode}, 16'h0001, "test entry");
      base = ~base;
      io(1'b0, 2'h1, 16'h0080);
      repeat (14) @(negedge i_mclk);
      io(1'b1, 2'h0, 16'h0000);
      chk(o_io_rdata, col_exp(base, 0), "looped column");
      repeat (30) @(negedge i_mclk);
      io(1'b0, 2'h2, 16'h0000);
      chk({15'h0000, o_test_mode}, 16'h0000, "test exit");
      // Ten columns into eight words with no reads
      ncol = 4'ha;
      gap = 2'h1;
      io(1'b0, 2'h1, 16'h0080);
      repeat (26) @(negedge i_mclk);
      io(1'b1, 2'h0, 16'h0000);
      chk({14'h0000, rep}, 16'h0001, "transfer after lost data");
      io(1'b1, 2'h1, 16'h0000);
      chk({14'h0000, o_io_rdata[6:5]}, 16'h0003, "lost and alarm");
      complete_run();
   end
endmodule
`default_nettype wire
